// ### verilog/adrt_pkg.sv
/*
 * Shared constants, carriers and helpers of the converter result and trigger register block.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses; each register is one word.
 */
package adrt_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam int unsigned IDX_W = 6;
	localparam logic [5:0] IDX_PIN_DISABLE = 6'h01;
	localparam logic [5:0] IDX_PIN_STATE = 6'h02;
	localparam logic [5:0] IDX_CTRL_B = 6'h03;
	localparam logic [5:0] IDX_RES_LO = 6'h04;
	localparam logic [5:0] IDX_RES_HI = 6'h05;
	localparam logic [5:0] IDX_CTRL_A = 6'h06;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h08;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h09;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned CA_ENABLE = 7;
	localparam int unsigned CA_START = 6;
	localparam int unsigned CA_AUTO = 5;
	localparam int unsigned CA_FLAG = 4;
	localparam int unsigned CA_IE = 3;
	localparam int unsigned CB_BIPOLAR = 7;
	localparam int unsigned CB_CMP_MUX = 6;
	localparam int unsigned CB_LEFT = 4;
	localparam int unsigned CB_TRIG_HI = 2;
	localparam int unsigned IRQ_DONE = 0;
	localparam int unsigned IRQ_DROP = 1;

	// ------------------------------------------------------------
	// Reset values and result limits
	// ------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [9:0] RST_RESULT = 10'h000;
	localparam logic [1:0] RST_IRQ = 2'h0;
	localparam logic [9:0] SAT_UNIPOLAR = 10'h3ff;
	localparam logic [9:0] BIP_MAX = 10'h1ff;
	localparam logic [9:0] BIP_MIN = 10'h200;

	// ------------------------------------------------------------
	// Trigger source codes
	// ------------------------------------------------------------
	localparam logic [2:0] TRIG_FREE = 3'h0;
	localparam logic [2:0] TRIG_COMPARATOR = 3'h1;
	localparam logic [2:0] TRIG_EXT_INT0 = 3'h2;
	localparam logic [2:0] TRIG_T0_CMP_A = 3'h3;
	localparam logic [2:0] TRIG_T0_OVF = 3'h4;
	localparam logic [2:0] TRIG_T1_CMP_B = 3'h5;
	localparam logic [2:0] TRIG_T1_OVF = 3'h6;
	localparam logic [2:0] TRIG_T1_CAPTURE = 3'h7;

	// ------------------------------------------------------------
	// Carriers to and from the converter core
	// ------------------------------------------------------------
	typedef struct packed {
		logic done;         // One-cycle completion pulse
		logic busy;         // Conversion in progress
		logic [10:0] diff;  // Signed input difference code
	} adrt_core_in_s;

	typedef struct packed {
		logic enable;       // Converter powered
		logic start;        // One-cycle start pulse
		logic bipolar;      // Gain stage in two-sided mode
		logic cmp_mux;      // Comparator multiplexer enable
	} adrt_core_out_s;

	// Two byte views of the stored result, high byte first
	function automatic logic [15:0] adrt_present(input logic [9:0] res, input logic left);
		adrt_present = left ? {res, 6'h00} : {6'h00, res};
	endfunction

endpackage

// ### verilog/adrt_regs.sv
/*
 * Register-side logic of the converter: result bytes with read lock, control register B,
 * control register A, trigger selection with edge detection, pin input disable and interrupt.
 * Assumes a converter core on clk_sys delivering a done pulse with a signed difference code,
 * trigger flags from on-chip peripherals on the same clock and asynchronous pin levels.
 */
// What this block does
// [RL1] Load result on each completion unless locked or a low-byte read is pending
// [RL2] Low-byte read locks result until high read
// [RL3] Software reads low byte before high byte
// [RL4] Right adjust: bits 9:8 high, 7:0 low
// [RL5] Left adjust: bits 9:2 high, 1:0 low-top
// [RL6] Left-adjust change alters presentation at once
// [RL7] Unipolar default; non-positive input saturates high
// [RL8] Bipolar gives ten-bit two's complement result
// [RL9] Reserved bits 5 and 3 read back written
// [RL10] Trigger select ignored unless auto trigger on
// [RL11] Rising edge of selected flag starts conversion
// [RL12] Switching to a set flag is an edge
// [RL13] Switching to free running never triggers
// [RL14] Trigger field decodes eight documented sources
// [RL15] Disable bit kills buffer, pin reads zero
// [RL16] Software disables unused analog pin buffers
// [RL17] Complete flag sets on update; free-run source
// [RL18] Auto-trigger enable starts on positive edges
// [RL19] Unused result bits read zero; reset zero
module adrt_regs #(
	parameter int unsigned ADDR_W = 8,
	parameter int unsigned RES_W = 10,
	parameter int unsigned PIN_N = 8
) (
	input wire logic clk_sys,                      // System clock, 40 MHz
	input wire logic rst_b,                        // Synchronous reset, active low
	input wire logic [ADDR_W-1:0] avs_address,     // Byte address
	input wire logic avs_read,                     // Read request
	input wire logic avs_write,                    // Write request
	input wire logic [3:0] avs_byteenable,         // Byte lanes of a write
	input wire logic [31:0] avs_writedata,         // Write data
	output logic [31:0] avs_readdata,              // Read data
	output logic avs_waitrequest,                  // Stall
	input wire adrt_pkg::adrt_core_in_s core_in,   // From converter core
	output adrt_pkg::adrt_core_out_s core_out,     // To converter core
	input wire logic [7:0] trig_flags,             // Peripheral flags, bit 0 unused
	input wire logic [PIN_N-1:0] pin_in,           // Asynchronous pin levels
	output logic [PIN_N-1:0] pin_buf_off,          // Digital buffer disable
	output logic irq                               // Level interrupt
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (RES_W != 10 || PIN_N != 8 || ADDR_W < adrt_pkg::IDX_W + 2)
	begin : g_bad_params
		$error("adrt_regs: unsupported parameter values");
	end

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic wait_ff;
	logic [31:0] readdata_ff;
	logic [7:0] ctrl_a_ff;
	logic [7:0] ctrl_b_ff;
	logic [9:0] result_ff;
	logic lock_ff;
	logic [PIN_N-1:0] pin_dis_ff;
	logic [PIN_N-1:0] pin_s1_ff;
	logic [PIN_N-1:0] pin_s2_ff;
	logic [PIN_N-1:0] pin_state_ff;
	logic [1:0] status_ff;
	logic [1:0] mask_ff;
	logic irq_ff;
	logic start_ff;
	logic lvl_prev_ff;
	logic [2:0] sel_prev_ff;

	logic [7:0] nxt_ctrl_a;
	logic [9:0] nxt_result;
	logic nxt_lock;
	logic [1:0] nxt_status;
	logic nxt_start;

	// Address match against a register index
	function automatic logic hit(input logic [5:0] idx);
		hit = avs_address == ADDR_W'({idx, 2'b00});
	endfunction

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire rd_acc = avs_read & ~wait_ff;
	wire wr_acc = avs_write & ~wait_ff & avs_byteenable[0];
	wire [7:0] wbyte = avs_writedata[7:0];
	wire hit_dis = hit(adrt_pkg::IDX_PIN_DISABLE);
	wire hit_pin = hit(adrt_pkg::IDX_PIN_STATE);
	wire hit_cb = hit(adrt_pkg::IDX_CTRL_B);
	wire hit_lo = hit(adrt_pkg::IDX_RES_LO);
	wire hit_hi = hit(adrt_pkg::IDX_RES_HI);
	wire hit_ca = hit(adrt_pkg::IDX_CTRL_A);
	wire hit_st = hit(adrt_pkg::IDX_IRQ_STATUS);
	wire hit_mk = hit(adrt_pkg::IDX_IRQ_MASK);
	wire wr_ca = wr_acc & hit_ca;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	wire conv_en = ctrl_a_ff[adrt_pkg::CA_ENABLE];
	wire auto_en = ctrl_a_ff[adrt_pkg::CA_AUTO];
	wire flag = ctrl_a_ff[adrt_pkg::CA_FLAG];
	wire left_adj = ctrl_b_ff[adrt_pkg::CB_LEFT];
	wire bipolar = ctrl_b_ff[adrt_pkg::CB_BIPOLAR];
	wire [2:0] trig_sel = ctrl_b_ff[adrt_pkg::CB_TRIG_HI:0];

	// ------------------------------------------------------------
	// Result formatting and load
	// ------------------------------------------------------------
	// Saturation of the signed difference per polarity mode
	wire diff_neg = core_in.diff[10];
	wire uni_sat = diff_neg | (core_in.diff == 11'h000);                // RL7
	wire bip_hi = ~diff_neg & core_in.diff[9];
	wire bip_lo = diff_neg & ~core_in.diff[9];
	wire [9:0] uni_val = uni_sat ? adrt_pkg::SAT_UNIPOLAR : core_in.diff[9:0];
	wire [9:0] bip_val = bip_hi ? adrt_pkg::BIP_MAX : bip_lo ? adrt_pkg::BIP_MIN : core_in.diff[9:0]; // RL8
	wire [9:0] fmt_val = bipolar ? bip_val : uni_val;

	// A low-byte read in flight also holds the result, keeping the pair coherent
	wire lo_pending = avs_read & hit_lo;
	wire load_ok = core_in.done & ~lock_ff & ~lo_pending;               // RL1
	wire drop = core_in.done & ~load_ok;
	assign nxt_result = load_ok ? fmt_val : result_ff;                   // RL1 RL2
	assign nxt_lock = (rd_acc & hit_lo) ? 1'b1 : (rd_acc & hit_hi) ? 1'b0 : lock_ff; // RL2

	// Presentation follows left adjust combinationally
	wire [15:0] present = adrt_pkg::adrt_present(result_ff, left_adj);  // RL4 RL5 RL6 RL19
	wire [7:0] res_hi = present[15:8];
	wire [7:0] res_lo = present[7:0];

	// ------------------------------------------------------------
	// Trigger selection and edge detection
	// ------------------------------------------------------------
	// Free running watches the completion flag, others the peripheral flags
	wire sel_lvl = (trig_sel == adrt_pkg::TRIG_FREE) ? flag : trig_flags[trig_sel]; // RL14 RL17
	wire to_free = (trig_sel == adrt_pkg::TRIG_FREE) & (sel_prev_ff != adrt_pkg::TRIG_FREE); // RL13
	wire trig_edge = sel_lvl & ~lvl_prev_ff & ~to_free;                  // RL11 RL12
	wire auto_go = auto_en & conv_en & trig_edge;                        // RL10 RL18
	// Software start needs the enable that the same write leaves behind
	wire sw_go = wr_ca & wbyte[adrt_pkg::CA_START] & wbyte[adrt_pkg::CA_ENABLE];
	assign nxt_start = (auto_go | sw_go) & ~core_in.busy;

	// ------------------------------------------------------------
	// Control A next value; completion flag set wins over clear
	// ------------------------------------------------------------
	wire flag_clr = wr_ca & wbyte[adrt_pkg::CA_FLAG];
	wire nxt_flag = load_ok | (flag & ~flag_clr);                        // RL17
	wire [7:0] ca_wr = {wbyte[7:5], 1'b0, wbyte[3:0]} & 8'hef & 8'hbf;
	wire [7:0] ca_keep = ctrl_a_ff & 8'hef;
	assign nxt_ctrl_a = (wr_ca ? ca_wr : ca_keep) | {3'h0, nxt_flag, 4'h0};

	// Sticky interrupt status, write one to clear, set wins
	wire [1:0] st_set = {drop, load_ok};
	wire [1:0] st_clr = (wr_acc & hit_st) ? wbyte[1:0] : 2'h0;
	assign nxt_status = st_set | (status_ff & ~st_clr);

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	wire start_rd = core_in.busy | start_ff;
	wire [7:0] ca_rd = {ctrl_a_ff[7], start_rd, ctrl_a_ff[5:0]};
	wire [7:0] rd_byte = hit_dis ? pin_dis_ff :
		hit_pin ? pin_state_ff :
		hit_cb ? ctrl_b_ff :
		hit_lo ? res_lo :
		hit_hi ? res_hi :
		hit_ca ? ca_rd :
		hit_st ? {6'h00, status_ff} :
		hit_mk ? {6'h00, mask_ff} : adrt_pkg::RST_BYTE;

	// ------------------------------------------------------------
	// Bus handshake: one wait cycle per access
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			wait_ff <= 1'b1;
			readdata_ff <= 32'h0000_0000;
		end
		else
		begin
			wait_ff <= ~((avs_read | avs_write) & wait_ff);
			if (avs_read & wait_ff)
				readdata_ff <= {24'h00_0000, rd_byte};
		end
	end

	// Software-written registers
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			ctrl_a_ff <= adrt_pkg::RST_BYTE;
			ctrl_b_ff <= adrt_pkg::RST_BYTE;
			pin_dis_ff <= adrt_pkg::RST_BYTE;
			mask_ff <= adrt_pkg::RST_IRQ;
		end
		else
		begin
			ctrl_a_ff <= nxt_ctrl_a;
			if (wr_acc & hit_cb)
				ctrl_b_ff <= wbyte;                                      // RL9 RL6
			if (wr_acc & hit_dis)
				pin_dis_ff <= wbyte;
			if (wr_acc & hit_mk)
				mask_ff <= wbyte[1:0];
		end
	end

	// Result, lock, status and interrupt
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			result_ff <= adrt_pkg::RST_RESULT;                           // RL19
			lock_ff <= 1'b0;
			status_ff <= adrt_pkg::RST_IRQ;
			irq_ff <= 1'b0;
		end
		else
		begin
			result_ff <= nxt_result;
			lock_ff <= nxt_lock;
			status_ff <= nxt_status;
			irq_ff <= |(status_ff & mask_ff);
		end
	end

	// Trigger history and start pulse
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			start_ff <= 1'b0;
			lvl_prev_ff <= 1'b0;
			sel_prev_ff <= adrt_pkg::TRIG_FREE;
		end
		else
		begin
			start_ff <= nxt_start;
			lvl_prev_ff <= sel_lvl;
			sel_prev_ff <= trig_sel;
		end
	end

	// Pin synchroniser and masked pin state
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			pin_s1_ff <= adrt_pkg::RST_BYTE;
			pin_s2_ff <= adrt_pkg::RST_BYTE;
			pin_state_ff <= adrt_pkg::RST_BYTE;
		end
		else
		begin
			pin_s1_ff <= pin_in;
			pin_s2_ff <= pin_s1_ff;
			pin_state_ff <= pin_s2_ff & ~pin_dis_ff;                     // RL15
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign avs_readdata = readdata_ff;
	assign avs_waitrequest = wait_ff;
	assign core_out = '{enable: conv_en, start: start_ff, bipolar: bipolar,
		cmp_mux: ctrl_b_ff[adrt_pkg::CB_CMP_MUX]};
	assign pin_buf_off = pin_dis_ff;                                     // RL15
	assign irq = irq_ff;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	// Completion loads the formatted value
	load_done_a: // RL1
		assert property (load_ok |=> result_ff == $past(fmt_val))
		else $error("result not loaded on completion");

	// Locked result ignores completions until high byte read
	lock_hold_a: // RL2
		assert property (rd_acc & hit_lo ##1 (!(avs_read & hit_hi))[*3] |-> lock_ff && $stable(result_ff))
		else $error("result changed while locked");

	// Right adjusted high byte answer
	right_adj_a: // RL4
		assert property (rd_acc & hit_hi & !left_adj & $stable(ctrl_b_ff) & $stable(result_ff)
			|-> avs_readdata == {30'h0000_0000, result_ff[9:8]})
		else $error("right adjusted high byte wrong");

	// Left adjusted low byte answer
	left_adj_a: // RL5
		assert property (rd_acc & hit_lo & left_adj & $stable(ctrl_b_ff) & $stable(result_ff)
			|-> avs_readdata == {24'h00_0000, result_ff[1:0], 6'h00})
		else $error("left adjusted low byte wrong");

	// High byte answer follows the layout in force at the read
	adj_now_a: // RL6
		assert property (avs_read & hit_hi & wait_ff |=> avs_readdata[7:0] ==
			($past(left_adj) ? $past(result_ff[9:2]) : {6'h00, $past(result_ff[9:8])}))
		else $error("left adjust change not immediate");

	// Unipolar non-positive input saturates
	uni_sat_a: // RL7
		assert property (load_ok & !bipolar & uni_sat |=> result_ff == adrt_pkg::SAT_UNIPOLAR)
		else $error("unipolar saturation missing");

	// Bipolar positive overflow clamps
	bip_clamp_a: // RL8
		assert property (load_ok & bipolar & bip_hi |=> result_ff == adrt_pkg::BIP_MAX)
		else $error("bipolar clamp missing");

	// Reserved bits read back as written
	rsv_keep_a: // RL9
		assert property (wr_acc & hit_cb |=> ctrl_b_ff[5] == $past(wbyte[5]) && ctrl_b_ff[3] == $past(wbyte[3]))
		else $error("reserved bits lost");

	// No auto start without auto trigger enable
	no_auto_a: // RL10
		assert property (!auto_en & !wr_ca |=> !core_out.start)
		else $error("start without auto trigger");

	// Rising edge of selected flag starts conversion
	auto_start_a: // RL11
		assert property (auto_en & conv_en & sel_lvl & !lvl_prev_ff & !to_free & !core_in.busy |=> core_out.start)
		else $error("edge did not start conversion");

	// Switch to free running is quiet
	free_quiet_a: // RL13
		assert property (to_free & !wr_ca |=> !core_out.start)
		else $error("free running switch triggered");

	// Busy core refuses every start
	busy_block_a:
		assert property (core_in.busy |=> !core_out.start)
		else $error("start while core busy");

	// Disabled pins read zero
	pin_zero_a: // RL15
		assert property (##1 (pin_state_ff & $past(pin_dis_ff)) == 8'h00)
		else $error("disabled pin reads one");

	// Flag set on completion, wins over clear
	flag_set_a: // RL17
		assert property (load_ok |=> flag && status_ff[adrt_pkg::IRQ_DONE])
		else $error("completion flag not set");

	// Interrupt follows unmasked status
	irq_level_a:
		assert property ((status_ff & mask_ff) != 2'h0 |=> irq)
		else $error("interrupt not raised");

	// Interrupt drops once nothing unmasked is pending
	irq_drop_a:
		assert property ((status_ff & mask_ff) == 2'h0 |=> !irq)
		else $error("interrupt stuck high");

	// Main scenarios
	cov_locked_drop: cover property (lock_ff & core_in.done);
	cov_auto_start: cover property (auto_go ##1 core_out.start);
	cov_left_read: cover property (rd_acc & hit_hi & left_adj);
	cov_to_free: cover property (to_free & flag);
	cov_sw_start: cover property (sw_go & !core_in.busy ##1 core_out.start);

endmodule

// ### sim/tb_adrt_regs.sv
/*
 * Self-checking bench of the converter result and trigger register block.
 * Assumes the block at its ports alone: the bench plays bus master, converter core and trigger flags.
 */
module tb_adrt_regs;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	adrt_pkg::adrt_core_in_s core_in = '0;
	adrt_pkg::adrt_core_out_s core_out;
	logic [7:0] trig_flags = 8'h00;
	logic [7:0] pin_in = 8'hff;
	logic [7:0] pin_buf_off;
	logic irq;
	int fail_count = 0;
	int checks = 0;
	logic [31:0] starts = 32'h0000_0000;
	logic [31:0] snap;

	adrt_regs #(.ADDR_W(8), .RES_W(10), .PIN_N(8)) dut (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.core_in(core_in),
		.core_out(core_out),
		.trig_flags(trig_flags),
		.pin_in(pin_in),
		.pin_buf_off(pin_buf_off),
		.irq(irq)
	);

	// Clock of 25 ns
	initial
	begin
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Count start pulses seen by the core
	always @(posedge clk_sys)
	begin
		if (core_out.start === 1'b1)
			starts <= starts + 32'h0000_0001;
	end

	// ------------------------------------------------------------
	// Verdict, comparison and bus tasks
	// ------------------------------------------------------------
	task automatic results();
		if (fail_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// One bus access; entered just after a rising edge, leaves one idle cycle
	task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] rd);
		int n;
		n = 0;
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h00_0000, wd};
		avs_read <= ~wr;
		avs_write <= wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0 && n < 20)
		begin
			@(posedge clk_sys);
			n++;
		end
		rd = avs_readdata[7:0];
		if (n >= 20)
		begin
			fail_count++;
			results();
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [7:0] unused;
		xfer(1'b1, idx, d, unused);
	endtask

	task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
		logic [7:0] v;
		xfer(1'b0, idx, 8'h00, v);
		check({24'h00_0000, v}, {24'h00_0000, exp});
	endtask

	// One completion pulse from the core with a difference code
	task automatic conv_done(input logic [10:0] d);
		core_in <= {1'b1, 1'b0, d};
		@(posedge clk_sys);
		core_in <= {1'b0, 1'b0, ~d};
		@(posedge clk_sys);
	endtask

	// Raise one trigger flag, count starts, drop it again
	task automatic flag_pulse(input int k, input logic [31:0] exp);
		snap = starts;
		trig_flags[k] <= 1'b1;
		repeat (4) @(posedge clk_sys);
		check(starts - snap, exp);
		trig_flags <= 8'h00;
		repeat (2) @(posedge clk_sys);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		// Reset values and unmapped place
		rd_chk(adrt_pkg::IDX_CTRL_B, 8'h00);
		rd_chk(adrt_pkg::IDX_RES_LO, 8'h00);
		rd_chk(adrt_pkg::IDX_RES_HI, 8'h00);
		rd_chk(adrt_pkg::IDX_PIN_DISABLE, 8'h00);
		rd_chk(6'h3f, 8'h00);
		check({31'h0, irq}, 32'h0000_0000);
		// Reserved bits hold what was written
		wr(adrt_pkg::IDX_CTRL_B, 8'h28);
		rd_chk(adrt_pkg::IDX_CTRL_B, 8'h28);
		avs_byteenable <= 4'he;
		wr(adrt_pkg::IDX_CTRL_B, 8'hff);
		avs_byteenable <= 4'hf;
		rd_chk(adrt_pkg::IDX_CTRL_B, 8'h28);
		// Right then left layout of one result
		conv_done(11'h2a5);
		rd_chk(adrt_pkg::IDX_RES_LO, 8'ha5);
		rd_chk(adrt_pkg::IDX_RES_HI, 8'h02);
		rd_chk(adrt_pkg::IDX_CTRL_A, 8'h10);
		wr(adrt_pkg::IDX_CTRL_B, 8'h10);
		rd_chk(adrt_pkg::IDX_RES_LO, 8'h40);
		rd_chk(adrt_pkg::IDX_RES_HI, 8'ha9);
		wr(adrt_pkg::IDX_CTRL_B, 8'h00);
		// Low read locks out a completion until high read
		rd_chk(adrt_pkg::IDX_RES_LO, 8'ha5);
		conv_done(11'h155);
		rd_chk(adrt_pkg::IDX_RES_HI, 8'h02);
		rd_chk(adrt_pkg::IDX_RES_LO, 8'ha5);
		rd_chk(adrt_pkg::IDX_RES_HI, 8'h02);
		rd_chk(adrt_pkg::IDX_IRQ_STATUS, 8'h03);
		conv_done(11'h155);
		rd_chk(adrt_pkg::IDX_RES_LO, 8'h55);
		rd_chk(adrt_pkg::IDX_RES_HI, 8'h01);
		// Unipolar saturation, then bipolar codes
		conv_done(11'h7f0);
		rd_chk(adrt_pkg::IDX_RES_LO, 8'hff);
		rd_chk(adrt_pkg::IDX_RES_HI, 8'h03);
		wr(adrt_pkg::IDX_CTRL_B, 8'hc0);
		check({31'h0, core_out.bipolar}, 32'h0000_0001);
		check({31'h0, core_out.cmp_mux}, 32'h0000_0001);
		conv_done(11'h7fd);
		rd_chk(adrt_pkg::IDX_RES_LO, 8'hfd);
		rd_chk(adrt_pkg::IDX_RES_HI, 8'h03);
		conv_done(11'h300);
		rd_chk(adrt_pkg::IDX_RES_LO, 8'hff);
		rd_chk(adrt_pkg::IDX_RES_HI, 8'h01);
		// Interrupt: mask, raise, clear
		wr(adrt_pkg::IDX_IRQ_MASK, 8'h02);
		repeat (2) @(posedge clk_sys);
		check({31'h0, irq}, 32'h0000_0001);
		wr(adrt_pkg::IDX_IRQ_STATUS, 8'h02);
		repeat (2) @(posedge clk_sys);
		check({31'h0, irq}, 32'h0000_0000);
		rd_chk(adrt_pkg::IDX_IRQ_STATUS, 8'h01);
		wr(adrt_pkg::IDX_IRQ_MASK, 8'h01);
		repeat (2) @(posedge clk_sys);
		check({31'h0, irq}, 32'h0000_0001);
		wr(adrt_pkg::IDX_IRQ_STATUS, 8'h01);
		repeat (2) @(posedge clk_sys);
		check({31'h0, irq}, 32'h0000_0000);
		// Each of the seven peripheral trigger sources (codes 1 to 7) starts one conversion
		wr(adrt_pkg::IDX_CTRL_B, 8'h00);
		wr(adrt_pkg::IDX_CTRL_A, 8'ha0);
		for (int k = 1; k < 8; k++)
		begin
			wr(adrt_pkg::IDX_CTRL_B, k[7:0]);
			flag_pulse(k, 32'h0000_0001);
		end
		// No start without auto trigger or without enable
		wr(adrt_pkg::IDX_CTRL_A, 8'h80);
		flag_pulse(7, 32'h0000_0000);
		wr(adrt_pkg::IDX_CTRL_A, 8'h20);
		flag_pulse(7, 32'h0000_0000);
		// Software start, refused while the core is busy
		core_in <= {1'b0, 1'b1, 11'h000};
		snap = starts;
		wr(adrt_pkg::IDX_CTRL_A, 8'hc0);
		rd_chk(adrt_pkg::IDX_CTRL_A, 8'hd0);
		check(starts - snap, 32'h0000_0000);
		core_in <= '0;
		wr(adrt_pkg::IDX_CTRL_A, 8'hc0);
		repeat (2) @(posedge clk_sys);
		check(starts - snap, 32'h0000_0001);
		check({31'h0, core_out.enable}, 32'h0000_0001);
		// Switching selection to a set flag is an edge
		wr(adrt_pkg::IDX_CTRL_A, 8'ha0);
		wr(adrt_pkg::IDX_CTRL_B, 8'h02);
		trig_flags <= 8'h08;
		repeat (3) @(posedge clk_sys);
		snap = starts;
		wr(adrt_pkg::IDX_CTRL_B, 8'h03);
		repeat (3) @(posedge clk_sys);
		check(starts - snap, 32'h0000_0001);
		// Free running choice never triggers, flag still set, old source clear
		trig_flags <= 8'h00;
		repeat (2) @(posedge clk_sys);
		snap = starts;
		wr(adrt_pkg::IDX_CTRL_B, 8'h00);
		repeat (3) @(posedge clk_sys);
		check(starts - snap, 32'h0000_0000);
		// Pin input disable
		wr(adrt_pkg::IDX_PIN_DISABLE, 8'h5a);
		check({24'h00_0000, pin_buf_off}, 32'h0000_005a);
		rd_chk(adrt_pkg::IDX_PIN_STATE, 8'ha5);
		rd_chk(adrt_pkg::IDX_PIN_DISABLE, 8'h5a);
		results();
	end
endmodule
